//--- logic/mcs_pkg.sv
// Constants and types for the microstep coil current sequencer
package mcs_pkg;
	// Register indices (word addresses)
	localparam logic [3:0] MCS_REG_CTRL = 4'h0;
	localparam logic [3:0] MCS_REG_CURLIM = 4'h1;
	localparam logic [3:0] MCS_REG_STEP = 4'h2;
	localparam logic [3:0] MCS_REG_STATUS = 4'h3;
	localparam logic [3:0] MCS_REG_COIL = 4'h4;
	localparam logic [3:0] MCS_REG_ERRCNT = 4'h5;
	localparam logic [3:0] MCS_REG_MAXSPD = 4'h6;
	// Control field positions
	localparam int MCS_CTRL_MODE_LSB = 0;
	localparam int MCS_CTRL_DECAY_LSB = 4;
	localparam int MCS_CTRL_DIR_BIT = 8;
	// Command bits in the step register
	localparam int MCS_STEP_PULSE_BIT = 0;
	localparam int MCS_STEP_RESUME_BIT = 1;
	localparam int MCS_STEP_APPLY_BIT = 2;
	localparam int MCS_STEP_DEFAULTS_BIT = 3;
	// Step mode codes
	localparam logic [3:0] MCS_MODE_FULL = 4'h0;
	localparam logic [3:0] MCS_MODE_HALF = 4'h1;
	localparam logic [3:0] MCS_MODE_QUARTER = 4'h2;
	localparam logic [3:0] MCS_MODE_EIGHTH = 4'h3;
	localparam logic [3:0] MCS_MODE_SIXTEENTH = 4'h4;
	localparam logic [3:0] MCS_MODE_THIRTYSECOND = 4'h5;
	localparam logic [3:0] MCS_MODE_FULL100 = 4'h6;
	localparam logic [3:0] MCS_MODE_HALF100 = 4'h7;
	// Decay mode codes
	localparam logic [2:0] MCS_DECAY_SLOW = 3'h0;
	localparam logic [2:0] MCS_DECAY_MIX25 = 3'h1;
	localparam logic [2:0] MCS_DECAY_MIX50 = 3'h2;
	localparam logic [2:0] MCS_DECAY_MIX75 = 3'h3;
	localparam logic [2:0] MCS_DECAY_FAST = 3'h4;
	localparam logic [2:0] MCS_DECAY_MIXED = 3'h1;
	localparam logic [2:0] MCS_DECAY_AUTO = 3'h7;
	// Driver variants
	localparam logic [1:0] MCS_VAR_FIVE_DECAY = 2'h0;
	localparam logic [1:0] MCS_VAR_THREE_DECAY = 2'h1;
	localparam logic [1:0] MCS_VAR_REDUCED = 2'h2;
	localparam logic [1:0] MCS_VAR_NONCIRC = 2'h3;
	// Reset values
	localparam logic [11:0] MCS_CURLIM_RST = 12'h000;
	localparam logic [31:0] MCS_MAXSPD_DEFAULT = 32'h001e_8480; // 200 pulses/s in pulses/10000 s
	localparam logic [31:0] MCS_MAXSPD_LIMIT = 32'h1dcd_6500; // 500,000,000
	// Table: 128 entries per electrical cycle at 1/32 resolution
	localparam int MCS_IDX_W = 7;
	localparam logic [15:0] MCS_FULL_SCALE = 16'h0100; // sine scale 1.0
	localparam logic [15:0] MCS_SEVENTY = 16'h00b5; // 0.707 of full scale
	typedef enum logic [2:0]
	{
		MCS_ST_SAFE = 3'b001,
		MCS_ST_DRIVE = 3'b010,
		MCS_ST_FAULT = 3'b100
	} mcs_state_t;
endpackage

//--- logic/mcs_sequencer.sv
// Microstep coil current sequencer with register port and safe-start control
//
// Summary of operation
// (R1) Full step: four equal-magnitude states, one coil flips
// (R2) Full step: each coil about seventy percent
// (R3) Microsteps of 1/2 to 1/32 step
// (R4) Thirty-two microsteps per full step finest
// (R5) Quarter step: 16 states, 3/7/11/15 diagonal
// (R6) Quarter step: 1/5/9/13 one coil full
// (R7) Between positions use unequal coil setpoints
// (R8) Allowed step modes depend on variant
// (R9) 100% modes: non-zero setpoints equal full current
// (R10) Rates counted in microstep pulses
// (R11) Default maximum speed is 200 pulses/s
// (R12) Low supply raises error, de-energizes motor
// (R13) Fault returns to safe start, counts
// (R14) New settings hold motor off until resume
// (R15) Resume without errors energizes and reports driving
// (R16) Host picks current limit from allowed values
// (R17) Host keeps limit within continuous rating
// (R18) Five-decay variant: slow/25/50/75/fast, 50 default
// (R19) Three-decay variant: slow/mixed/fast, mixed default; code accepts codes 0 to 2, not fast (4)
// (R20) Other variants decay chosen automatically
// (R21) Each pulse moves index one, wraps
// (R22) Mode change keeps nearest electrical angle
// (R23) Speeds in pulses per 10000 s, capped
`timescale 1ns/1ps
module mcs_sequencer
	import mcs_pkg::*;
#(
	parameter logic [1:0] VARIANT = MCS_VAR_FIVE_DECAY
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [31:0] reg_rdata,
	input wire logic supply_undervoltage_raw,
	output logic [11:0] coil_a_setpoint,
	output logic coil_a_negative,
	output logic [11:0] coil_b_setpoint,
	output logic coil_b_negative,
	output logic coil_enable,
	output logic [2:0] decay_select,
	output logic supply_undervoltage_error
);

	// All block state in one register; d is its next value
	// Field order is free; software never sees this layout
	typedef struct packed {
		mcs_state_t state;
		logic [3:0] mode;
		logic [2:0] decay;
		logic dir;
		logic [11:0] curlim;
		logic [31:0] maxspd;
		logic [MCS_IDX_W-1:0] idx;
		logic [15:0] errcnt;
		logic [2:0] uv_sync;
		logic uv_level;
		logic [31:0] rdata;
		logic [11:0] coil_a;
		logic [11:0] coil_b;
		logic neg_a;
		logic neg_b;
	} mcs_regs_t;

	mcs_regs_t q, d;

	// Sine magnitude for 0..32 steps of a quarter cycle, scale 256
	function automatic logic [15:0] mcs_sine(input logic [5:0] k);
		// Quarter wave only; quadrant logic adds sign and coil swap
		logic [15:0] t [0:32];
		t = '{
			16'h0000, // 0 degrees
			16'h000d,
			16'h0019,
			16'h0026,
			16'h0032,
			16'h003e,
			16'h004a,
			16'h0056,
			16'h0062,
			16'h006d,
			16'h0079,
			16'h0084,
			16'h008e,
			16'h0098,
			16'h00a2,
			16'h00ac,
			16'h00b5, // 45 degrees
			16'h00be,
			16'h00c6,
			16'h00ce,
			16'h00d5,
			16'h00dc,
			16'h00e2,
			16'h00e7,
			16'h00ed,
			16'h00f1,
			16'h00f5,
			16'h00f8,
			16'h00fb,
			16'h00fd,
			16'h00ff,
			16'h0100,
			16'h0100 // 90 degrees
		};
		return t[k];
	endfunction

	// Index step per pulse: 128-entry cycle divided by the mode
	function automatic logic [MCS_IDX_W-1:0] mcs_stride(input logic [3:0] m);
		case (m)
			MCS_MODE_FULL, MCS_MODE_FULL100: return 7'h20;
			MCS_MODE_HALF, MCS_MODE_HALF100: return 7'h10;
			MCS_MODE_QUARTER: return 7'h08;
			MCS_MODE_EIGHTH: return 7'h04;
			MCS_MODE_SIXTEENTH: return 7'h02;
			MCS_MODE_THIRTYSECOND: return 7'h01;
			default: return 7'h20;
		endcase
	endfunction

	// Modes each variant accepts
	function automatic logic mcs_mode_ok(input logic [3:0] m);
		case (VARIANT)
			MCS_VAR_REDUCED: return m <= MCS_MODE_EIGHTH; // (R8)
			// The non-circular variant has no plain full step
			MCS_VAR_NONCIRC: return m != MCS_MODE_FULL && m <= MCS_MODE_HALF100; // (R8)
			default: return m <= MCS_MODE_THIRTYSECOND; // (R8)
		endcase
	endfunction

	// Decay codes each variant accepts
	function automatic logic mcs_decay_ok(input logic [2:0] c);
		case (VARIANT)
			MCS_VAR_FIVE_DECAY: return c <= MCS_DECAY_FAST; // (R18)
			// Auto-decay variants refuse every write; the bridge picks decay
			MCS_VAR_THREE_DECAY: return c <= 3'h2; // (R19)
			default: return 1'b0; // (R20)
		endcase
	endfunction

	// Decay code after reset, per variant
	function automatic logic [2:0] mcs_decay_rst();
		case (VARIANT)
			MCS_VAR_FIVE_DECAY: return MCS_DECAY_MIX50; // (R18)
			MCS_VAR_THREE_DECAY: return MCS_DECAY_MIXED; // (R19)
			default: return MCS_DECAY_AUTO; // (R20)
		endcase
	endfunction

	// Step mode after reset, legal for every variant
	function automatic logic [3:0] mcs_mode_rst();
		return (VARIANT == MCS_VAR_NONCIRC) ? MCS_MODE_FULL100 : MCS_MODE_FULL;
	endfunction

	// Next state and register port
	// Every field of d gets a value on every path through d = q
	always_comb
	begin
		// Scratch values, all cleared at the top so no latch appears
		logic [MCS_IDX_W-1:0] stride;
		logic [MCS_IDX_W-1:0] nstride;
		logic [4:0] phase;
		logic [1:0] quad;
		logic [15:0] sa;
		logic [15:0] sb;
		logic [27:0] pa;
		logic [27:0] pb;
		logic hundred;
		logic pulse;
		logic [3:0] nmode;
		stride = '0;
		nstride = '0;
		phase = '0;
		quad = '0;
		sa = '0;
		sb = '0;
		pa = '0;
		pb = '0;
		hundred = 1'b0;
		pulse = 1'b0;
		nmode = '0;
		// Hold everything unless a branch below changes it
		d = q;
		d.rdata = '0;
		// Undervoltage pin through three flops; change taken when last two agree
		// Agreement rejects a pin edge caught mid-transition
		d.uv_sync = {q.uv_sync[1:0], supply_undervoltage_raw};
		if (q.uv_sync[2] == q.uv_sync[1])
			d.uv_level = q.uv_sync[2];
		// Stride of the mode in force, for a pulse this cycle
		stride = mcs_stride(q.mode);

		// Register writes
		if (reg_we)
		begin
			case (reg_addr)
				MCS_REG_CTRL:
				begin
					// Illegal mode or decay codes leave the old value in place
					nmode = reg_wdata[MCS_CTRL_MODE_LSB +: 4];
					if (mcs_mode_ok(nmode))
					begin
						d.mode = nmode;
						nstride = mcs_stride(nmode);
						// Snap to nearest angle on the coarser grid
						// Full modes sit on odd multiples of 45 degrees
						if (nmode == MCS_MODE_FULL || nmode == MCS_MODE_FULL100)
							d.idx = (q.idx & 7'h60) | 7'h10; // (R22) (R1)
						else
							d.idx = (q.idx + (nstride >> 1)) & ~(nstride - 7'h01); // (R22)
					end
					if (mcs_decay_ok(reg_wdata[MCS_CTRL_DECAY_LSB +: 3]))
						d.decay = reg_wdata[MCS_CTRL_DECAY_LSB +: 3]; // (R18)
					// Direction applies from the next pulse on
					d.dir = reg_wdata[MCS_CTRL_DIR_BIT];
				end
				// Limit taken as given; picking a legal value is the host's job
				MCS_REG_CURLIM: d.curlim = reg_wdata[11:0];
				MCS_REG_MAXSPD:
					// Pulses per 10000 s, clamped at the ceiling
					// Clamp rather than wrap, so an oversize write stays fast
					d.maxspd = (reg_wdata > MCS_MAXSPD_LIMIT) ? MCS_MAXSPD_LIMIT : reg_wdata; // (R23)
				MCS_REG_STEP:
				begin
					pulse = reg_wdata[MCS_STEP_PULSE_BIT];
					// Restore resets only the speed limit here and drops to safe start
					// Apply and restore win over resume in one write
					if (reg_wdata[MCS_STEP_DEFAULTS_BIT])
						d.maxspd = MCS_MAXSPD_DEFAULT; // (R11)
					if (reg_wdata[MCS_STEP_APPLY_BIT] || reg_wdata[MCS_STEP_DEFAULTS_BIT])
						d.state = MCS_ST_SAFE; // (R14)
					else if (reg_wdata[MCS_STEP_RESUME_BIT] && !q.uv_level)
						d.state = MCS_ST_DRIVE; // (R15)
				end
				default: ;
			endcase
		end

		// One pulse is one microstep of the current mode
		// Pulses outside drive are dropped, not queued
		if (pulse && q.state == MCS_ST_DRIVE)
			d.idx = q.dir ? q.idx - stride : q.idx + stride; // (R21) (R10) (R4) (R3)

		// Supply fault overrides apply and resume and is counted once per entry
		// A held low supply therefore counts only once
		case (q.state)
			MCS_ST_DRIVE:
				if (q.uv_level)
				begin
					d.state = MCS_ST_FAULT; // (R12)
					d.errcnt = q.errcnt + 16'h0001; // (R13)
				end
			MCS_ST_FAULT: d.state = MCS_ST_SAFE; // (R13)
			MCS_ST_SAFE: ;
			default: d.state = MCS_ST_SAFE;
		endcase

		// Register reads, data one cycle later
		// Reads see the state before this cycle's writes
		// Unmapped indices read back as zero; the step index reads back the position index
		if (reg_re)
		begin
			case (reg_addr)
				MCS_REG_CTRL: d.rdata = {23'h0, q.dir, 1'b0, q.decay, q.mode};
				MCS_REG_CURLIM: d.rdata = {20'h0, q.curlim};
				MCS_REG_STATUS: d.rdata = {28'h0, q.uv_level, q.state};
				MCS_REG_COIL: d.rdata = {q.neg_b, 3'h0, q.coil_b, q.neg_a, 3'h0, q.coil_a};
				MCS_REG_ERRCNT: d.rdata = {16'h0, q.errcnt};
				MCS_REG_MAXSPD: d.rdata = q.maxspd;
				MCS_REG_STEP: d.rdata = {25'h0, q.idx};
				default: d.rdata = '0;
			endcase
		end

		// Setpoints: angle idx*90/32 degrees; cos on coil A, sin on coil B
		quad = q.idx[6:5];
		phase = q.idx[4:0];
		sa = mcs_sine(6'(32 - phase)); // (R7) (R6)
		sb = mcs_sine({1'b0, phase}); // (R7)
		// Odd quadrants swap which coil follows the cosine
		if (quad[0])
		begin
			sa = mcs_sine({1'b0, phase}); // (R7) (R6)
			sb = mcs_sine(6'(32 - phase)); // (R7)
		end
		// Only the two 100% modes square the pattern off
		hundred = (q.mode == MCS_MODE_FULL100) || (q.mode == MCS_MODE_HALF100);
		if (hundred)
		begin
			// Non-circular: any non-zero coil takes the full limit
			sa = (sa != 16'h0) ? MCS_FULL_SCALE : 16'h0; // (R9)
			sb = (sb != 16'h0) ? MCS_FULL_SCALE : 16'h0; // (R9)
		end
		// Full step sits on odd multiples of 45 degrees
		if (q.mode == MCS_MODE_FULL)
		begin
			sa = MCS_SEVENTY; // (R1) (R2)
			sb = MCS_SEVENTY; // (R1) (R2)
		end
		// Product keeps 8 fraction bits; bits 19:8 are whole current units
		pa = 28'(q.curlim) * 28'(sa);
		pb = 28'(q.curlim) * 28'(sb);
		// Outside drive both coils read zero so the bridges idle
		d.coil_a = (q.state == MCS_ST_DRIVE) ? pa[19:8] : 12'h000; // (R12) (R15)
		d.coil_b = (q.state == MCS_ST_DRIVE) ? pb[19:8] : 12'h000; // (R12) (R15)

		// Polarity by quadrant; each full step flips one coil
		d.neg_a = quad[1] ^ quad[0]; // (R1) (R5)
		d.neg_b = quad[1]; // (R1) (R5)
	end

	// State register
	// Synchronous reset; functions give per-variant constant defaults
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			q <= '0;
			q.state <= MCS_ST_SAFE;
			q.mode <= mcs_mode_rst();
			q.decay <= mcs_decay_rst();
			q.curlim <= MCS_CURLIM_RST;
			q.maxspd <= MCS_MAXSPD_DEFAULT; // (R11)
			// Diagonal start keeps full mode legal from the first pulse
			q.idx <= 7'h10; // Start on a 45 degree point
		end
		else
			q <= d;
	end

	// Outputs from flops
	// Enable decoded straight from the state flop, no extra delay
	assign reg_rdata = q.rdata;
	assign coil_a_setpoint = q.coil_a;
	assign coil_b_setpoint = q.coil_b;
	assign coil_a_negative = q.neg_a;
	assign coil_b_negative = q.neg_b;
	assign coil_enable = (q.state == MCS_ST_DRIVE); // (R14) (R15)
	assign decay_select = q.decay;
	assign supply_undervoltage_error = q.uv_level; // (R12)

endmodule

//--- bench/mcs_checker.sv
// Port assertions for the microstep coil current sequencer
`timescale 1ns/1ps
module mcs_checker
	import mcs_pkg::*;
#(
	parameter logic [1:0] VARIANT = MCS_VAR_FIVE_DECAY
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_we,
	input wire logic supply_undervoltage_raw,
	input wire logic [11:0] coil_a_setpoint,
	input wire logic [11:0] coil_b_setpoint,
	input wire logic coil_enable,
	input wire logic [2:0] decay_select,
	input wire logic supply_undervoltage_error
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Decoded writes; decay checks only hold for the five-decay variant
	wire logic cmd_w = reg_we && reg_addr == MCS_REG_STEP;
	wire logic ctl_w = reg_we && reg_addr == MCS_REG_CTRL && VARIANT == MCS_VAR_FIVE_DECAY;
	// Pin held high long enough to pass the synchronizer
	sequence s_uv_held;
		$rose(supply_undervoltage_raw) ##1 supply_undervoltage_raw[*5];
	endsequence
	sequence s_clean_resume;
		cmd_w && reg_wdata[3:1] == 3'h1 && !supply_undervoltage_error && !supply_undervoltage_raw;
	endsequence
	a_off_zero: assert property (!coil_enable && !$past(coil_enable) |->
		coil_a_setpoint == 12'h000 && coil_b_setpoint == 12'h000) else $error("current while off");
	a_uv_seen: assert property (s_uv_held |-> supply_undervoltage_error) else $error("uv missed");
	a_uv_off: assert property (supply_undervoltage_error |-> ##[0:2] !coil_enable) else $error("uv on");
	a_resume_uv: assert property (cmd_w && reg_wdata[1] && supply_undervoltage_error |=>
		!coil_enable[*2]) else $error("resume under uv");
	a_resume_drive: assert property (s_clean_resume |=> coil_enable) else $error("no drive");
	a_apply_safe: assert property (cmd_w && reg_wdata[2] |=> !coil_enable) else $error("apply");
	a_decay_write: assert property (ctl_w && reg_wdata[6:4] <= MCS_DECAY_FAST |=>
		decay_select == $past(reg_wdata[6:4])) else $error("decay not taken");
	a_decay_refuse: assert property (ctl_w && reg_wdata[6:4] > MCS_DECAY_FAST |=>
		$stable(decay_select)) else $error("bad decay taken");
endmodule
bind mcs_sequencer mcs_checker #(.VARIANT(VARIANT)) u_mcs_checker (.clk, .rst, .reg_addr,
	.reg_wdata, .reg_we, .supply_undervoltage_raw, .coil_a_setpoint, .coil_b_setpoint,
	.coil_enable, .decay_select, .supply_undervoltage_error);

//--- bench/mcs_motor_model.sv
// Motor and supply model whose voltage sags under coil load
`timescale 1ns/1ps
module mcs_motor_model
(
	input wire logic coil_enable,
	input wire logic weak_supply,
	input wire logic brownout,
	output logic supply_undervoltage_raw
);
	// A weak supply only dips once the bridges draw current
	always_comb
	begin
		supply_undervoltage_raw = brownout | (weak_supply & coil_enable);
	end
endmodule

//--- bench/test_microstep_coil_current_sequencer.sv
// Self-checking bench for the microstep coil current sequencer
`timescale 1ns/1ps
module test_microstep_coil_current_sequencer;
	import mcs_pkg::*;
	typedef struct packed {logic [11:0] ctrl; logic [5:0] n; logic [6:0] idx; logic chk;
		logic [25:0] coil;} mcs_row_t;
	logic clk, rst, reg_we, reg_re, uv_raw, coil_enable, weak_supply, brownout, uv_err;
	logic neg_a, neg_b;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v;
	logic [11:0] set_a, set_b;
	logic [2:0] decay_select;
	int mismatches = 0, total_checks = 0, cycles = 0;
	// Mode/dir, steps, index, coil check, {negB,B,negA,A}
	mcs_row_t rows [10] = '{
		'{12'h000, 6'd1, 7'd48, 1'b1, 26'h016b0b5},
		'{12'h000, 6'd1, 7'd80, 1'b1, 26'h216b0b5},
		'{12'h002, 6'd2, 7'd96, 1'b1, 26'h2200000},
		'{12'h102, 6'd4, 7'd64, 1'b1, 26'h2001100},
		'{12'h005, 6'd32, 7'd96, 1'b1, 26'h2200000},
		'{12'h005, 6'd3, 7'd99, 1'b0, 26'h0},
		'{12'h002, 6'd0, 7'd96, 1'b1, 26'h2200000},
		'{12'h101, 6'd1, 7'd80, 1'b1, 26'h216b0b5},
		'{12'h104, 6'd4, 7'd72, 1'b0, 26'h0},
		'{12'h003, 6'd2, 7'd80, 1'b1, 26'h216b0b5}};
	mcs_sequencer dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .supply_undervoltage_raw(uv_raw),
		.coil_a_setpoint(set_a), .coil_a_negative(neg_a), .coil_b_setpoint(set_b),
		.coil_b_negative(neg_b), .coil_enable(coil_enable), .decay_select(decay_select),
		.supply_undervoltage_error(uv_err));
	mcs_motor_model u_motor (.coil_enable(coil_enable), .weak_supply(weak_supply),
		.brownout(brownout), .supply_undervoltage_raw(uv_raw));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Strobe stays up; the next rd or nop lowers it
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		reg_re <= 1'b0;
		@(posedge clk);
	endtask
	task automatic nop(input int n);
		reg_we <= 1'b0;
		reg_re <= 1'b0;
		repeat (n) @(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_we <= 1'b0;
		reg_re <= 1'b1;
		@(posedge clk);
		reg_re <= 1'b0;
		#1 d = reg_rdata;
		@(posedge clk);
	endtask
	// Hang guard, far above the few hundred cycles needed
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			give_verdict();
		end
	end
	initial
	begin
		rst = 1'b1;
		{reg_we, reg_re, weak_supply, brownout} = 4'h0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		nop(2);
		chk("decay reset", 32'h2, {29'h0, decay_select});
		rd(MCS_REG_MAXSPD, v);
		chk("max speed", 32'(200 * 10000), v);
		wr(MCS_REG_CURLIM, 32'h100);
		wr(MCS_REG_STEP, 32'h2);
		nop(2);
		chk("enable", 32'h1, {31'h0, coil_enable});
		rd(MCS_REG_STATUS, v);
		chk("status", 32'h2, v);
		foreach (rows[i])
		begin
			wr(MCS_REG_CTRL, {20'h0, rows[i].ctrl});
			repeat (rows[i].n) wr(MCS_REG_STEP, 32'h1);
			nop(3);
			rd(MCS_REG_STEP, v);
			chk("index", {25'h0, rows[i].idx}, v);
			if (rows[i].chk)
				chk("coils", {6'h0, rows[i].coil}, {6'h0, neg_b, set_b, neg_a, set_a});
		end
		// Apply drops to safe start and freezes stepping
		wr(MCS_REG_STEP, 32'h4);
		wr(MCS_REG_STEP, 32'h1);
		nop(2);
		chk("apply off", 32'h0, {19'h0, coil_enable, set_a});
		rd(MCS_REG_STEP, v);
		chk("frozen index", 32'd80, v);
		rd(MCS_REG_COIL, v);
		chk("coil reg", 32'h8000_8000, v);
		rd(4'h9, v);
		chk("unmapped", 32'h0, v);
		brownout <= 1'b1;
		nop(6);
		chk("uv flag", 32'h1, {31'h0, uv_err});
		wr(MCS_REG_STEP, 32'h2);
		nop(2);
		chk("refused", 32'h0, {31'h0, coil_enable});
		brownout <= 1'b0;
		nop(8);
		// Supply sags each time the coils draw current
		weak_supply <= 1'b1;
		for (int k = 1; k < 3; k++)
		begin
			wr(MCS_REG_STEP, 32'h2);
			nop(14);
			chk("fault off", 32'h0, {31'h0, coil_enable});
			rd(MCS_REG_ERRCNT, v);
			chk("fault count", 32'(k), v);
			rd(MCS_REG_STATUS, v);
			chk("safe again", 32'h1, v & 32'h7);
		end
		weak_supply <= 1'b0;
		wr(MCS_REG_MAXSPD, 32'hffff_ffff);
		rd(MCS_REG_MAXSPD, v);
		chk("speed cap", 32'd500_000_000, v);
		wr(MCS_REG_STEP, 32'h8);
		rd(MCS_REG_MAXSPD, v);
		chk("restored", 32'(200 * 10000), v);
		for (int d = 0; d < 6; d++)
		begin
			wr(MCS_REG_CTRL, 32'(d * 16 + 3));
			nop(1);
			chk("decay", (d < 5) ? 32'(d) : 32'h4, {29'h0, decay_select});
		end
		wr(MCS_REG_CTRL, 32'h046);
		rd(MCS_REG_CTRL, v);
		chk("mode refused", 32'h043, v & 32'h1ff);
		give_verdict();
	end
endmodule
